// >>> rtl/servo_status_outputs.sv
`timescale 1ns/1ps
`include "servo_status_map.svh"
module servo_status_outputs
    import servo_status_pkg::*;
#(
    parameter int SCALE_WIDTH = 16,
    parameter int COUNTS_PER_REV = 4000
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic alarmActive,
    input wire logic alarmClearable,
    input wire logic mainSupplyOk,
    input wire logic controlSupplyOk,
    input wire logic absoluteMode,
    input wire logic absoluteTransferDone,
    input wire logic brakeRelease,
    input wire logic inPositionCond,
    input wire logic inPositionSecondCond,
    input wire logic torqueClamped,
    input wire logic zeroSpeedCond,
    input wire logic [7:0] warningsActive,
    input wire logic [`WARN_SEL_WIDTH-1:0] warning_select_first,
    input wire logic [`WARN_SEL_WIDTH-1:0] warning_select_second,
    input wire logic positionCommandPresent,
    input wire logic dcBusLow,
    input wire logic [3:0] output_pin_select_one,
    input wire logic [3:0] output_pin_select_two,
    input wire logic [3:0] output_pin_select_three,
    input wire logic selectExternalScale,
    input wire logic encoderStep,
    input wire logic encoderDir,
    input wire logic scaleStep,
    input wire logic scaleDir,
    input wire logic [SCALE_WIDTH-1:0] scaleNumerator,
    input wire logic [SCALE_WIDTH-1:0] scaleDenominator,
    output logic alarm_status_out,
    output logic servoReadyOut,
    output logic brake_release_out,
    output logic in_position_out,
    output logic in_position_second_out,
    output logic torque_limited_out,
    output logic zero_speed_out,
    output logic warning_first_out,
    output logic warning_second_out,
    output logic commandPresentOut,
    output logic clearable_alarm_out,
    output logic mainPowerOut,
    output logic status_pin_one,
    output logic status_pin_two,
    output logic status_pin_three,
    output logic phase_a_pulse_pos,
    output logic phase_a_pulse_neg,
    output logic phase_b_pulse_pos,
    output logic phase_b_pulse_neg,
    output logic phase_z_pulse_pos,
    output logic phase_z_pulse_neg,
    output logic phase_z_single_ended,
    output logic scaledStepDropped
);
    localparam int MIN_GAP = `MIN_EDGE_CYCLES;
    localparam int AW = SCALE_WIDTH + 1;

    ready_state_t readyState_reg;
    ready_state_t readyState_next;
    logic suppliesOk;
    logic readyLevel;
    logic [12:0] funcLevel;
    logic [AW-1:0] acc_reg;
    logic [AW-1:0] accSum;
    logic srcStep;
    logic srcDir;
    logic pendValid_reg;
    logic pendDir_reg;
    logic stepReady;
    logic emitStep;
    logic srcAccept;
    logic stepBlocked;
    logic qa;
    logic qb;
    logic qz;

    assign suppliesOk = mainSupplyOk && controlSupplyOk;

    // Shared by the dedicated output and the pin router, so both switch on
    // the same edge.
    assign readyLevel = (readyState_next == RDY_ON) && suppliesOk
        && !alarmActive;

    // Ready drops immediately on alarm or supply loss and, in absolute mode,
    // re-arms only after a fresh position data transfer.
    always_comb begin
        readyState_next = readyState_reg;
        case (readyState_reg)
            RDY_WAIT: begin
                if (suppliesOk && !alarmActive) begin
                    readyState_next = absoluteMode ? RDY_XFER : RDY_ON;
                end
            end
            RDY_XFER: begin
                // A drop while waiting demands a fresh transfer.
                if (!suppliesOk || alarmActive) begin
                    readyState_next = RDY_WAIT;
                end else if (absoluteTransferDone) begin
                    readyState_next = RDY_ON;
                end
            end
            RDY_ON: begin
                if (!suppliesOk || alarmActive) begin
                    readyState_next = RDY_WAIT;
                end
            end
            default: readyState_next = RDY_WAIT;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            readyState_reg <= RDY_WAIT;
        end else begin
            readyState_reg <= readyState_next;
        end
    end

    // Every status output is registered so all pins switch on one edge and
    // the host never sees a glitch from the decode.
    always_ff @(posedge clock) begin
        if (reset) begin
            alarm_status_out <= 1'h0;
            servoReadyOut <= 1'h0;
            brake_release_out <= 1'h0;
            in_position_out <= 1'h0;
            in_position_second_out <= 1'h0;
            torque_limited_out <= 1'h0;
            zero_speed_out <= 1'h0;
            warning_first_out <= 1'h0;
            warning_second_out <= 1'h0;
            commandPresentOut <= 1'h0;
            clearable_alarm_out <= 1'h0;
            mainPowerOut <= 1'h0;
        end else begin
            alarm_status_out <= !alarmActive;
            servoReadyOut <= readyLevel;
            brake_release_out <= brakeRelease;
            in_position_out <= inPositionCond;
            in_position_second_out <= inPositionSecondCond;
            torque_limited_out <= torqueClamped;
            zero_speed_out <= zeroSpeedCond;
            warning_first_out <= warningsActive[warning_select_first];
            warning_second_out <=
                warningsActive[warning_select_second];
            commandPresentOut <= positionCommandPresent;
            clearable_alarm_out <= alarmActive && alarmClearable;
            mainPowerOut <= dcBusLow;
        end
    end

    // Function levels indexed by out_func_t; index 0 is the idle level.
    always_comb begin
        funcLevel = '0;
        funcLevel[FN_ALARM] = !alarmActive;
        funcLevel[FN_READY] = readyLevel;
        funcLevel[FN_INPOS] = inPositionCond;
        funcLevel[FN_BRAKE] = brakeRelease;
        funcLevel[FN_TORQUE] = torqueClamped;
        funcLevel[FN_ZSPEED] = zeroSpeedCond;
        funcLevel[FN_INPOS2] = inPositionSecondCond;
        funcLevel[FN_WARNFIRST] = warningsActive[warning_select_first];
        funcLevel[FN_WARNSECOND] = warningsActive[warning_select_second];
        funcLevel[FN_CMD] = positionCommandPresent;
        funcLevel[FN_CLRALM] = alarmActive && alarmClearable;
        funcLevel[FN_MAINPWR] = dcBusLow;
    end

    // Selector codes beyond the table leave the pin off rather than aliasing.
    function automatic logic pickLevel(input logic [3:0] sel,
                                       input logic [12:0] lv);
        logic r;
        r = 1'h0;
        if (sel <= 4'hC) begin
            r = lv[sel];
        end
        return r;
    endfunction : pickLevel

    // Pins are decoded anew every cycle, so a selector change takes effect
    // on the next edge.
    always_ff @(posedge clock) begin
        if (reset) begin
            status_pin_one <= 1'h0;
            status_pin_two <= 1'h0;
            status_pin_three <= 1'h0;
        end else begin
            status_pin_one <= pickLevel(output_pin_select_one,
                funcLevel);
            status_pin_two <= pickLevel(output_pin_select_two,
                funcLevel);
            status_pin_three <= pickLevel(output_pin_select_three,
                funcLevel);
        end
    end

    assign srcStep = selectExternalScale ? scaleStep : encoderStep;
    assign srcDir = selectExternalScale ? scaleDir : encoderDir;
    assign accSum = acc_reg + AW'(scaleNumerator);
    // While the generator still holds a pending step the source is refused,
    // and the accumulator holds rather than count a step that is lost.
    assign stepBlocked = pendValid_reg && !stepReady;
    assign srcAccept = srcStep && !stepBlocked;

    // Rational scaler: each accepted source step adds the numerator, and one output
    // step is issued whenever the sum reaches a nonzero denominator. A ratio of
    // one or less keeps at most one step pending.
    always_ff @(posedge clock) begin
        if (reset) begin
            acc_reg <= '0;
        end else if (srcAccept) begin
            if (accSum >= AW'(scaleDenominator)) begin
                acc_reg <= accSum - AW'(scaleDenominator);
            end else begin
                acc_reg <= accSum;
            end
        end
    end

    assign emitStep = srcAccept && (accSum >= AW'(scaleDenominator))
        && (scaleDenominator != '0);

    always_ff @(posedge clock) begin
        if (reset) begin
            pendValid_reg <= 1'h0;
            pendDir_reg <= 1'h0;
        end else if (emitStep) begin
            pendValid_reg <= 1'h1;
            pendDir_reg <= srcDir;
        end else if (stepReady) begin
            pendValid_reg <= 1'h0;
        end
    end

    // A source step that meets a still-blocked pending step is lost; the
    // flag lets firmware see that the scaled rate ran past the cap.
    always_ff @(posedge clock) begin
        if (reset) begin
            scaledStepDropped <= 1'h0;
        end else begin
            scaledStepDropped <= srcStep && stepBlocked;
        end
    end

    quad_pulse_gen #(
        .MIN_GAP(MIN_GAP),
        .COUNTS_PER_REV(COUNTS_PER_REV)
    ) pulseGen (
        .clock(clock),
        .reset(reset),
        .stepValid(pendValid_reg),
        .stepDir(pendDir_reg),
        .stepReady(stepReady),
        .phaseA(qa),
        .phaseB(qb),
        .phaseZ(qz)
    );

    // Both legs of a pair come from one register stage, so the pair never
    // skews; the negative legs reset high so each pair rests complementary.
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_a_pulse_pos <= 1'h0;
            phase_a_pulse_neg <= 1'h1;
            phase_b_pulse_pos <= 1'h0;
            phase_b_pulse_neg <= 1'h1;
            phase_z_pulse_pos <= 1'h0;
            phase_z_pulse_neg <= 1'h1;
            phase_z_single_ended <= 1'h0;
        end else begin
            phase_a_pulse_pos <= qa;
            phase_a_pulse_neg <= !qa;
            phase_b_pulse_pos <= qb;
            phase_b_pulse_neg <= !qb;
            phase_z_pulse_pos <= qz;
            phase_z_pulse_neg <= !qz;
            phase_z_single_ended <= qz;
        end
    end
endmodule : servo_status_outputs

// >>> rtl/servo_status_pkg.sv
package servo_status_pkg;
    typedef enum logic [3:0] {
        FN_NONE = 4'h0,
        FN_ALARM = 4'h1,
        FN_READY = 4'h2,
        FN_INPOS = 4'h3,
        FN_BRAKE = 4'h4,
        FN_TORQUE = 4'h5,
        FN_ZSPEED = 4'h6,
        FN_INPOS2 = 4'h7,
        FN_WARNFIRST = 4'h8,
        FN_WARNSECOND = 4'h9,
        FN_CMD = 4'hA,
        FN_CLRALM = 4'hB,
        FN_MAINPWR = 4'hC
    } out_func_t;

    typedef enum logic [2:0] {
        RDY_WAIT = 3'h1,
        RDY_XFER = 3'h2,
        RDY_ON = 3'h4
    } ready_state_t;
endpackage : servo_status_pkg

// >>> rtl/servo_status_map.svh
`ifndef SERVO_STATUS_MAP_SVH
`define SERVO_STATUS_MAP_SVH
`define CLOCK_HZ 125000000
`define MAX_EDGE_RATE_PPS 4000000
`define MIN_EDGE_CYCLES \
    ((`CLOCK_HZ + `MAX_EDGE_RATE_PPS - 1) / `MAX_EDGE_RATE_PPS)
`define PIN_ONE_DEFAULT 4'h1
`define PIN_TWO_DEFAULT 4'h3
`define PIN_THREE_DEFAULT 4'h2
`define WARN_SEL_WIDTH 3
`endif

// >>> rtl/quad_pulse_gen.sv
`timescale 1ns/1ps
// Turns a signed step request into quadrature edges, one edge at a time,
// spaced at least MIN_GAP cycles apart.
module quad_pulse_gen #(
    parameter int MIN_GAP = 32,
    parameter int COUNTS_PER_REV = 4000
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic stepValid,
    input wire logic stepDir,
    output logic stepReady,
    output logic phaseA,
    output logic phaseB,
    output logic phaseZ
);
    localparam int GW = $clog2(MIN_GAP + 1);
    localparam int PW = $clog2(COUNTS_PER_REV + 1);
    logic [GW-1:0] gap_reg;
    logic [1:0] phase_reg;
    logic [PW-1:0] pos_reg;
    logic step;
    logic [1:0] phaseNext;

    assign stepReady = (gap_reg == '0);
    assign step = stepValid && stepReady;
    // Gray order 00,01,11,10: forward makes A lead B.
    assign phaseNext = stepDir ? phase_reg - 2'h1 : phase_reg + 2'h1;

    always_ff @(posedge clock) begin
        if (reset) begin
            gap_reg <= '0;
        end else if (step) begin
            gap_reg <= GW'(MIN_GAP - 1);
        end else if (gap_reg != '0) begin
            gap_reg <= gap_reg - GW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_reg <= 2'h0;
            pos_reg <= '0;
        end else if (step) begin
            phase_reg <= phaseNext;
            if (!stepDir) begin
                pos_reg <= (pos_reg == PW'(COUNTS_PER_REV - 1)) ?
                    '0 : pos_reg + PW'(1);
            end else begin
                pos_reg <= (pos_reg == '0) ?
                    PW'(COUNTS_PER_REV - 1) : pos_reg - PW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            phaseA <= 1'h0;
            phaseB <= 1'h0;
            phaseZ <= 1'h0;
        end else begin
            phaseA <= phase_reg[1] ^ phase_reg[0];
            phaseB <= phase_reg[1];
            phaseZ <= (pos_reg == '0);
        end
    end
endmodule : quad_pulse_gen

// >>> tb/servo_status_properties.sv
`timescale 1ns/1ps
`include "servo_status_map.svh"
module servo_status_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic alarmActive,
    input wire logic alarmClearable,
    input wire logic mainSupplyOk,
    input wire logic controlSupplyOk,
    input wire logic inPositionCond,
    input wire logic torqueClamped,
    input wire logic [7:0] warningsActive,
    input wire logic [`WARN_SEL_WIDTH-1:0] warning_select_first,
    input wire logic [3:0] output_pin_select_one,
    input wire logic alarm_status_out,
    input wire logic servoReadyOut,
    input wire logic in_position_out,
    input wire logic torque_limited_out,
    input wire logic warning_first_out,
    input wire logic clearable_alarm_out,
    input wire logic status_pin_one,
    input wire logic phase_a_pulse_pos,
    input wire logic phase_a_pulse_neg,
    input wire logic phase_b_pulse_pos,
    input wire logic phase_z_pulse_pos,
    input wire logic phase_z_single_ended
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [7:0] gapCount;
    logic [1:0] lastAb;
    logic armed;
    logic abEdge;
    assign abEdge = {phase_a_pulse_pos, phase_b_pulse_pos} != lastAb;
    // The gap saturates so a long idle spell never wraps into a short one.
    always_ff @(posedge clock) begin
        if (reset) begin
            lastAb <= 2'h0;
            gapCount <= 8'h0;
            armed <= 1'h0;
        end else begin
            lastAb <= {phase_a_pulse_pos, phase_b_pulse_pos};
            if (abEdge) begin
                gapCount <= 8'h1;
                armed <= 1'h1;
            end else if (gapCount != 8'hFF) begin
                gapCount <= gapCount + 8'h1;
            end
        end
    end
    alarm_level_a: assert property (!$past(reset) |->
        alarm_status_out == !$past(alarmActive)) else $error("alarm level");
    ready_cause_a: assert property (servoReadyOut |->
        $past(mainSupplyOk && controlSupplyOk && !alarmActive))
        else $error("ready without cause");
    inpos_follow_a: assert property (!$past(reset) |->
        in_position_out == $past(inPositionCond)) else $error("in-position");
    torque_follow_a: assert property (!$past(reset) |->
        torque_limited_out == $past(torqueClamped)) else $error("torque");
    warn_select_a: assert property (!$past(reset) |->
        warning_first_out == $past(warningsActive[warning_select_first]))
        else $error("warning select");
    clear_class_a: assert property (clearable_alarm_out |->
        $past(alarmClearable)) else $error("clearable alarm");
    pin_route_a: assert property (!$past(reset) &&
        $past(output_pin_select_one) == 4'h3 |->
        status_pin_one == $past(inPositionCond)) else $error("pin route");
    pin_unassigned_a: assert property (!$past(reset) &&
        ($past(output_pin_select_one) == 4'h0 ||
        $past(output_pin_select_one) > 4'hC) |-> !status_pin_one)
        else $error("unassigned pin");
    diff_pair_a: assert property (
        phase_a_pulse_neg == !phase_a_pulse_pos) else $error("pair");
    z_copy_a: assert property (
        phase_z_single_ended == phase_z_pulse_pos) else $error("z copy");
    edge_gap_a: assert property (abEdge && armed |->
        gapCount >= 8'h20) else $error("edge gap");
endmodule : servo_status_checker
bind servo_status_outputs servo_status_checker chk (.clock, .reset,
    .alarmActive, .alarmClearable, .mainSupplyOk, .controlSupplyOk,
    .inPositionCond, .torqueClamped, .warningsActive, .warning_select_first,
    .output_pin_select_one, .alarm_status_out, .servoReadyOut,
    .in_position_out, .torque_limited_out, .warning_first_out,
    .clearable_alarm_out, .status_pin_one, .phase_a_pulse_pos,
    .phase_a_pulse_neg, .phase_b_pulse_pos, .phase_z_pulse_pos,
    .phase_z_single_ended);

// >>> tb/host_reader.sv
`timescale 1ns/1ps
// Host side: decodes the quadrature pair into a position count.
module host_reader (
    input wire logic clock,
    input wire logic reset,
    input wire logic aPos,
    input wire logic aNeg,
    input wire logic bPos,
    input wire logic bNeg,
    input wire logic zNeg,
    input wire logic zPos,
    output int position,
    output logic wireFault
);
    logic [1:0] delta;
    logic [1:0] lastPhase;
    assign delta = {bPos, aPos ^ bPos} - lastPhase;
    always_ff @(posedge clock) begin
        if (reset) begin
            lastPhase <= 2'h0;
            position <= 0;
            wireFault <= 1'h0;
        end else begin
            lastPhase <= {bPos, aPos ^ bPos};
            if (delta == 2'h1) begin
                position <= position + 1;
            end else if (delta == 2'h3) begin
                position <= position - 1;
            end else if (delta == 2'h2) begin
                wireFault <= 1'h1;
            end
            if (aNeg === aPos || bNeg === bPos || zNeg === zPos) begin
                wireFault <= 1'h1;
            end
        end
    end
endmodule : host_reader

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic alarmActive = 1'h0, alarmClearable = 1'h0, mainSupplyOk = 1'h0;
    logic controlSupplyOk = 1'h0, absoluteMode = 1'h0, brakeRelease = 1'h0;
    logic absoluteTransferDone = 1'h0, inPositionCond = 1'h0;
    logic inPositionSecondCond = 1'h0, torqueClamped = 1'h0;
    logic zeroSpeedCond = 1'h0, positionCommandPresent = 1'h0;
    logic dcBusLow = 1'h0, selectExternalScale = 1'h0, encoderStep = 1'h0;
    logic encoderDir = 1'h0, scaleStep = 1'h0, scaleDir = 1'h0;
    logic [7:0] warningsActive = 8'h0;
    logic [2:0] warning_select_first = 3'h0, warning_select_second = 3'h0;
    logic [3:0] output_pin_select_one = 4'h0, output_pin_select_two = 4'h0;
    logic [3:0] output_pin_select_three = 4'h0;
    logic [15:0] scaleNumerator = 16'h1, scaleDenominator = 16'h1;
    logic alarm_status_out, servoReadyOut, brake_release_out, in_position_out;
    logic in_position_second_out, torque_limited_out, zero_speed_out;
    logic warning_first_out, warning_second_out, commandPresentOut;
    logic clearable_alarm_out, mainPowerOut, phase_z_single_ended;
    logic status_pin_one, status_pin_two, status_pin_three;
    logic phase_a_pulse_pos, phase_a_pulse_neg, phase_b_pulse_pos;
    logic phase_b_pulse_neg, phase_z_pulse_pos, phase_z_pulse_neg;
    logic scaledStepDropped, wireFault;
    int fail_count = 0;
    int compares = 0;
    int dropCount = 0;
    int hostCount;
    servo_status_outputs dut (.*);
    host_reader host (.clock, .reset, .aPos(phase_a_pulse_pos),
        .aNeg(phase_a_pulse_neg), .bPos(phase_b_pulse_pos),
        .bNeg(phase_b_pulse_neg), .zPos(phase_z_pulse_pos),
        .zNeg(phase_z_pulse_neg), .position(hostCount), .wireFault);
    always #4 clock = ~clock;
    always @(posedge clock) if (scaledStepDropped === 1'h1) dropCount++;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic drive(input logic v);
        {brakeRelease, inPositionCond, inPositionSecondCond} <= {3{v}};
        {torqueClamped, zeroSpeedCond, positionCommandPresent} <= {3{v}};
        {dcBusLow, mainSupplyOk, controlSupplyOk} <= {3{v}};
        warningsActive <= {8{v}};
    endtask : drive
    task automatic pinScan(input logic [15:0] expMap);
        for (int c = 0; c < 16; c++) begin
            output_pin_select_one <= 4'(c);
            cyc(2);
            check(status_pin_one, expMap[c]);
        end
    endtask : pinScan
    task automatic pulse(input logic dir, input logic ext);
        encoderDir <= dir;
        scaleDir <= dir;
        encoderStep <= !ext;
        scaleStep <= ext;
        cyc(1);
        encoderStep <= 1'h0;
        scaleStep <= 1'h0;
        cyc(40);
    endtask : pulse
    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
    initial begin
        cyc(12);
        reset <= 1'h0;
        cyc(2);
        check(alarm_status_out, 1'h1);
        pinScan(16'h0002);
        check(phase_z_pulse_pos, 1'h1);
        drive(1'h1);
        cyc(2);
        check({servoReadyOut, brake_release_out, in_position_out,
            in_position_second_out, torque_limited_out, zero_speed_out,
            commandPresentOut, mainPowerOut}, 8'hFF);
        check({warning_first_out, warning_second_out}, 2'h3);
        pinScan(16'h17FE);
        $display("status levels done");
        inPositionCond <= 1'h0;
        output_pin_select_two <= 4'h3;
        output_pin_select_three <= 4'h2;
        cyc(2);
        check({in_position_out, in_position_second_out}, 2'h1);
        check({status_pin_two, status_pin_three}, 2'h1);
        alarmActive <= 1'h1;
        alarmClearable <= 1'h1;
        cyc(2);
        check({alarm_status_out, servoReadyOut}, 2'h0);
        check(clearable_alarm_out, 1'h1);
        check(status_pin_three, 1'h0);
        alarmClearable <= 1'h0;
        cyc(2);
        check(clearable_alarm_out, 1'h0);
        alarmActive <= 1'h0;
        mainSupplyOk <= 1'h0;
        cyc(2);
        check(servoReadyOut, 1'h0);
        absoluteMode <= 1'h1;
        mainSupplyOk <= 1'h1;
        cyc(5);
        check(servoReadyOut, 1'h0);
        absoluteTransferDone <= 1'h1;
        cyc(1);
        absoluteTransferDone <= 1'h0;
        cyc(2);
        check(servoReadyOut, 1'h1);
        absoluteMode <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            warningsActive <= 8'h1 << i;
            warning_select_first <= 3'(i);
            warning_select_second <= 3'(i + 1);
            cyc(2);
            check({warning_first_out, warning_second_out}, 2'h2);
        end
        $display("ready and warnings done");
        repeat (3) pulse(1'h0, 1'h0);
        check(8'(hostCount), 8'h3);
        check(phase_z_pulse_pos, 1'h0);
        repeat (3) pulse(1'h1, 1'h0);
        check(8'(hostCount), 8'h0);
        check(phase_z_pulse_pos, 1'h1);
        selectExternalScale <= 1'h1;
        scaleDenominator <= 16'h2;
        repeat (4) pulse(1'h0, 1'h1);
        check(8'(hostCount), 8'h2);
        selectExternalScale <= 1'h0;
        scaleDenominator <= 16'h1;
        encoderStep <= 1'h1;
        cyc(5);
        encoderStep <= 1'h0;
        cyc(300);
        check(8'(hostCount + dropCount), 8'h7);
        check(dropCount > 0, 1'h1);
        check(wireFault, 1'h0);
        drive(1'h0);
        cyc(2);
        check({brake_release_out, torque_limited_out, zero_speed_out,
            commandPresentOut, mainPowerOut, servoReadyOut},
            8'h0);
        $display("pulse outputs done");
        conclude();
    end
endmodule : testbench
